// *** core/ebp_port.sv ***
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
// Overview of operation
// - a direction bit of one turns that pin's driver off so the pin is an input.
// - a direction bit of zero drives the pin from its output latch bit.
// - the output latch is its own register and reads return the latch, not the pins.
// - eight pins each have their own direction bit and work independently.
// - the parallel slave enable bit (bit 4 of the neighbour direction register) makes
//      the whole port a host data port.
// - while the parallel slave port is active it owns every pin whatever the direction bits say.
// - dual or quad pwm output mode switches the parallel slave functions off.
// - pins 0 to 3 read as zero while the analog comparator input is selected.
// - after reset pins 0 to 3 have the comparator input selected and direction bits set.
// - after reset every direction bit is set so all pins are inputs.
// - pins 4 to 7 carry pwm channels a to d, which drive only once software clears direction.
// - the neighbour direction register holds input full, output full, overflow and enable.
module ebp_port #(
    parameter int unsigned ADDR_W = ebp_pkg::ADDR_W
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // port pins, driven while pad_oe_n is low
    input wire logic [7:0] pad_in,
    output logic [7:0] pad_out,
    output logic [7:0] pad_oe_n,
    // parallel slave handshake block
    input wire logic host_drive_en,
    input wire logic [7:0] host_out_data,
    input wire logic input_full_flag,
    input wire logic output_full_flag,
    input wire logic input_overflow_set,
    output logic [7:0] host_in_data,
    output logic parallel_slave_active,
    // enhanced pwm generator
    input wire logic pwm_channel_a,
    input wire logic pwm_channel_b,
    input wire logic pwm_channel_c,
    input wire logic pwm_channel_d,
    input wire logic [3:0] pwm_owns_pin,
    input wire logic pwm_multi_output,
    // comparator inputs and neighbour port
    output logic comparator_one_plus,
    output logic comparator_one_minus,
    output logic comparator_two_plus,
    output logic comparator_two_minus,
    output logic [2:0] neighbour_dir
);
    // registers
    logic [7:0] pin_direction_q;
    logic [7:0] output_latch_q;
    logic [2:0] neighbour_dir_q;
    logic parallel_slave_enable_q;
    logic input_overflow_q;
    logic analog_sel_q;
    logic [31:0] prdata_q;
    logic [7:0] pad_out_q;
    logic [7:0] pad_oe_n_q;
    logic [7:0] host_in_q;
    logic [3:0] comp_q;

    // decoded bus view
    ebp_pkg::ebp_reg_t reg_sel;
    logic setup_read;
    logic access_write;
    logic access_miss;
    logic [7:0] wbyte;
    logic [7:0] ndir_read;
    logic host_active;

    // carrier toward the pin mux
    ebp_pin_if pin ();

    ebp_apb_decode u_decode (
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr[11:0]),
        .reg_sel(reg_sel),
        .setup_read(setup_read),
        .access_write(access_write),
        .access_miss(access_miss)
    );

    ebp_pin_mux u_mux (
        .pin(pin)
    );

    // narrow registers take the low byte only
    assign wbyte = pwdata[7:0];

    // multi-output pwm needs pins the parallel slave would otherwise own
    assign host_active = parallel_slave_enable_q && !pwm_multi_output;

    // steer the pin mux from the register state
    assign pin.dir = pin_direction_q;
    assign pin.latch = output_latch_q;
    assign pin.host_active = host_active;
    assign pin.host_drive = host_drive_en;
    assign pin.host_dout = host_out_data;
    assign pin.pwm_own = pwm_owns_pin;
    assign pin.pwm_val = {pwm_channel_d, pwm_channel_c, pwm_channel_b, pwm_channel_a};
    assign pin.analog_sel = analog_sel_q;
    assign pin.pad_level = pad_in;

    // direction register: one bit per pin, all inputs out of reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_direction_q <= ebp_pkg::PIN_DIRECTION_RST;
        end else if (access_write && reg_sel == ebp_pkg::EBP_REG_PIN_DIRECTION) begin
            pin_direction_q <= wbyte;
        end
    end

    // output latch: written through either the latch or the pin level address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            output_latch_q <= ebp_pkg::OUTPUT_LATCH_RST;
        end else if (access_write && (reg_sel == ebp_pkg::EBP_REG_OUTPUT_LATCH
                                      || reg_sel == ebp_pkg::EBP_REG_PIN_LEVEL)) begin
            output_latch_q <= wbyte;
        end
    end

    // neighbour direction bits and parallel slave enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            neighbour_dir_q <= ebp_pkg::NEIGHBOUR_DIR_RST;
            parallel_slave_enable_q <= ebp_pkg::HOST_ENABLE_RST;
        end else if (access_write && reg_sel == ebp_pkg::EBP_REG_NEIGHBOUR_DIR) begin
            neighbour_dir_q <= wbyte[ebp_pkg::NDIR_DIR_W-1:0];
            parallel_slave_enable_q <= wbyte[ebp_pkg::NDIR_HOST_ENABLE_BIT];
        end
    end

    // overflow is sticky; software clears it by writing zero, a new overflow wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            input_overflow_q <= 1'b0;
        end else if (input_overflow_set) begin
            input_overflow_q <= 1'b1;
        end else if (access_write && reg_sel == ebp_pkg::EBP_REG_NEIGHBOUR_DIR
                     && !wbyte[ebp_pkg::NDIR_OVERFLOW_BIT]) begin
            input_overflow_q <= 1'b0;
        end
    end

    // analog comparator selection for pins 0 to 3
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog_sel_q <= ebp_pkg::ANALOG_SEL_RST;
        end else if (access_write && reg_sel == ebp_pkg::EBP_REG_ALT_CONFIG) begin
            analog_sel_q <= wbyte[ebp_pkg::ALT_ANALOG_SEL_BIT];
        end
    end

    // flags in the upper nibble, direction bits below, bit 3 reads zero
    always_comb begin
        ndir_read = {5'h00, neighbour_dir_q};
        ndir_read[ebp_pkg::NDIR_INPUT_FULL_BIT] = input_full_flag;
        ndir_read[ebp_pkg::NDIR_OUTPUT_FULL_BIT] = output_full_flag;
        ndir_read[ebp_pkg::NDIR_OVERFLOW_BIT] = input_overflow_q;
        ndir_read[ebp_pkg::NDIR_HOST_ENABLE_BIT] = parallel_slave_enable_q;
    end

    // read data sampled in the setup phase; a write in the same access is not seen
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h00000000;
        end else if (setup_read) begin
            unique case (reg_sel)
                ebp_pkg::EBP_REG_PIN_LEVEL: prdata_q <= {24'h000000, pin.digital_in};
                ebp_pkg::EBP_REG_OUTPUT_LATCH: prdata_q <= {24'h000000, output_latch_q};
                ebp_pkg::EBP_REG_PIN_DIRECTION: prdata_q <= {24'h000000, pin_direction_q};
                ebp_pkg::EBP_REG_NEIGHBOUR_DIR: prdata_q <= {24'h000000, ndir_read};
                ebp_pkg::EBP_REG_ALT_CONFIG: prdata_q <= {31'h00000000, analog_sel_q};
                ebp_pkg::EBP_REG_NONE: prdata_q <= 32'h00000000;
            endcase
        end
    end

    // zero wait state slave; misses answer with an error and read zero
    assign pready = 1'b1;
    assign pslverr = access_miss;
    assign prdata = prdata_q;

    // pins come out of flops so the pads never see decode glitches
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pad_out_q <= 8'h00;
            pad_oe_n_q <= 8'hFF;
        end else begin
            pad_out_q <= pin.drive_val;
            pad_oe_n_q <= ~pin.drive_en;
        end
    end

    // host data and comparator levels, one flop behind the pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            host_in_q <= 8'h00;
            comp_q <= 4'h0;
        end else begin
            host_in_q <= pad_in;
            comp_q <= analog_sel_q ? pad_in[3:0] : 4'h0;
        end
    end

    // outputs
    assign pad_out = pad_out_q;
    assign pad_oe_n = pad_oe_n_q;
    assign host_in_data = host_in_q;
    assign parallel_slave_active = host_active;
    assign comparator_one_plus = comp_q[0];
    assign comparator_one_minus = comp_q[1];
    assign comparator_two_plus = comp_q[2];
    assign comparator_two_minus = comp_q[3];
    assign neighbour_dir = neighbour_dir_q;
endmodule : ebp_port

// *** inc/ebp_pkg.sv ***
package ebp_pkg;
    // port geometry
    localparam int unsigned PIN_COUNT = 8;
    localparam int unsigned ANALOG_PINS = 4;
    localparam int unsigned PWM_FIRST_PIN = 4;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;

    // register byte addresses, one aligned word each
    localparam logic [11:0] OFS_PIN_LEVEL = 12'h000;
    localparam logic [11:0] OFS_OUTPUT_LATCH = 12'h004;
    localparam logic [11:0] OFS_PIN_DIRECTION = 12'h008;
    localparam logic [11:0] OFS_NEIGHBOUR_DIR = 12'h00C;
    localparam logic [11:0] OFS_ALT_CONFIG = 12'h010;

    // register index produced by the decoder
    typedef enum logic [2:0] {
        EBP_REG_PIN_LEVEL,
        EBP_REG_OUTPUT_LATCH,
        EBP_REG_PIN_DIRECTION,
        EBP_REG_NEIGHBOUR_DIR,
        EBP_REG_ALT_CONFIG,
        EBP_REG_NONE
    } ebp_reg_t;

    // neighbour direction register fields
    localparam int unsigned NDIR_INPUT_FULL_BIT = 7;
    localparam int unsigned NDIR_OUTPUT_FULL_BIT = 6;
    localparam int unsigned NDIR_OVERFLOW_BIT = 5;
    localparam int unsigned NDIR_HOST_ENABLE_BIT = 4;
    localparam int unsigned NDIR_DIR_W = 3;

    // alternate function config fields
    localparam int unsigned ALT_ANALOG_SEL_BIT = 0;

    // reset values
    localparam logic [7:0] PIN_DIRECTION_RST = 8'hFF;
    localparam logic [7:0] OUTPUT_LATCH_RST = 8'h00;
    localparam logic [2:0] NEIGHBOUR_DIR_RST = 3'h7;
    localparam logic HOST_ENABLE_RST = 1'b0;
    localparam logic ANALOG_SEL_RST = 1'b1;
endpackage : ebp_pkg

// *** inc/ebp_pin_if.sv ***
`timescale 1ns/1ps
interface ebp_pin_if;
    logic [7:0] dir;
    logic [7:0] latch;
    logic host_active;
    logic host_drive;
    logic [7:0] host_dout;
    logic [3:0] pwm_own;
    logic [3:0] pwm_val;
    logic analog_sel;
    logic [7:0] pad_level;
    logic [7:0] drive_en;
    logic [7:0] drive_val;
    logic [7:0] digital_in;

    // register side steers, pin mux answers
    modport ctl (output dir, latch, host_active, host_drive, host_dout, pwm_own, pwm_val,
                 analog_sel, pad_level, input drive_en, drive_val, digital_in);
    modport mux (input dir, latch, host_active, host_drive, host_dout, pwm_own, pwm_val,
                 analog_sel, pad_level, output drive_en, drive_val, digital_in);
endinterface : ebp_pin_if

// *** core/ebp_pin_mux.sv ***
`timescale 1ns/1ps
module ebp_pin_mux (
    // control and pin view
    ebp_pin_if.mux pin
);
    // one slice per pin; parallel slave beats pwm beats the plain latch path
    for (genvar i = 0; i < ebp_pkg::PIN_COUNT; i++) begin : g_pin
        logic pwm_here;
        logic pwm_bit;
        logic analog_here;
        // channel index only formed where it exists, so low pins never index below zero
        if (i >= ebp_pkg::PWM_FIRST_PIN) begin : g_pwm
            assign pwm_here = pin.pwm_own[i - ebp_pkg::PWM_FIRST_PIN];
            assign pwm_bit = pin.pwm_val[i - ebp_pkg::PWM_FIRST_PIN];
        end else begin : g_nopwm
            assign pwm_here = 1'b0;
            assign pwm_bit = 1'b0;
        end
        assign analog_here = (i < ebp_pkg::ANALOG_PINS) && pin.analog_sel;
        // parallel slave ignores the direction bit entirely
        assign pin.drive_en[i] = pin.host_active ? pin.host_drive : ~pin.dir[i];
        assign pin.drive_val[i] = pin.host_active ? pin.host_dout[i] :
                                  pwm_here ? pwm_bit :
                                  pin.latch[i];
        // analog pins read low on the digital side
        assign pin.digital_in[i] = analog_here ? 1'b0 : pin.pad_level[i];
    end
endmodule : ebp_pin_mux

// *** core/ebp_apb_decode.sv ***
`timescale 1ns/1ps
module ebp_apb_decode (
    // bus request
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    // decoded view
    output ebp_pkg::ebp_reg_t reg_sel,
    output logic setup_read,
    output logic access_write,
    output logic access_miss
);
    // word decode; low address bits are ignored since every register is one word
    always_comb begin
        unique case ({paddr[11:2], 2'b00})
            ebp_pkg::OFS_PIN_LEVEL: reg_sel = ebp_pkg::EBP_REG_PIN_LEVEL;
            ebp_pkg::OFS_OUTPUT_LATCH: reg_sel = ebp_pkg::EBP_REG_OUTPUT_LATCH;
            ebp_pkg::OFS_PIN_DIRECTION: reg_sel = ebp_pkg::EBP_REG_PIN_DIRECTION;
            ebp_pkg::OFS_NEIGHBOUR_DIR: reg_sel = ebp_pkg::EBP_REG_NEIGHBOUR_DIR;
            ebp_pkg::OFS_ALT_CONFIG: reg_sel = ebp_pkg::EBP_REG_ALT_CONFIG;
            default: reg_sel = ebp_pkg::EBP_REG_NONE;
        endcase
    end

    // read data is captured in setup so it can leave a flop in access
    assign setup_read = psel && !penable && !pwrite;
    assign access_write = psel && penable && pwrite && (reg_sel != ebp_pkg::EBP_REG_NONE);
    assign access_miss = psel && penable && (reg_sel == ebp_pkg::EBP_REG_NONE);
endmodule : ebp_apb_decode

// *** tb/ebp_pad_model.sv ***
`timescale 1ns/1ps
module ebp_pad_model (
    // device side of each pin
    input wire logic [7:0] pad_out,
    input wire logic [7:0] pad_oe_n,
    // what the board puts on released pins
    input wire logic [7:0] ext_val,
    input wire logic [7:0] ext_en,
    output logic [7:0] pad_in
);
    // an enabled device driver wins; an undriven pin floats up on its board pull-up
    assign pad_in = (~pad_oe_n & pad_out) | (pad_oe_n & ~ext_en)
        | (pad_oe_n & ext_en & ext_val);
endmodule : ebp_pad_model

// *** tb/ebp_port_checker.sv ***
`timescale 1ns/1ps
module ebp_port_checker #(parameter int unsigned ADDR_W = 12) (
    // clock and register bus
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    // pins and side blocks
    input wire logic [7:0] pad_out,
    input wire logic [7:0] pad_oe_n,
    input wire logic host_drive_en,
    input wire logic [7:0] host_out_data,
    input wire logic input_full_flag,
    input wire logic parallel_slave_active,
    input wire logic pwm_channel_a,
    input wire logic [3:0] pwm_owns_pin,
    input wire logic pwm_multi_output
);
    localparam int IW = ADDR_W - 2;
    logic wr, rd, ana_q;
    logic [IW-1:0] idx;
    assign idx = paddr[ADDR_W-1:2];
    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    // shadow of analog select, the only state that pin reads hinge on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) ana_q <= 1'b1;
        else if (wr && idx == IW'(4)) ana_q <= pwdata[0];
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // pins move one edge after the register that steers them
    property p_dir_oe;
        wr && idx == IW'(2) ##1 !parallel_slave_active |=> pad_oe_n == $past(pwdata[7:0], 2);
    endproperty
    a_dir_oe: assert property (p_dir_oe) else $error("oe off direction");
    property p_latch_out;
        wr && idx < IW'(2) ##1 !parallel_slave_active && pwm_owns_pin == 4'h0
        |=> pad_out == $past(pwdata[7:0], 2); endproperty
    a_latch_out: assert property (p_latch_out) else $error("pin off latch");
    property p_host_drive;
        parallel_slave_active && host_drive_en
        |=> pad_oe_n == 8'h00 && pad_out == $past(host_out_data); endproperty
    a_host_drive: assert property (p_host_drive) else $error("slave port not driving");
    property p_host_idle;
        parallel_slave_active && !host_drive_en |=> pad_oe_n == 8'hFF; endproperty
    a_host_idle: assert property (p_host_idle) else $error("slave port not released");
    property p_multi_off;
        pwm_multi_output |-> !parallel_slave_active; endproperty
    a_multi_off: assert property (p_multi_off) else $error("slave port not locked out");
    property p_analog_rd;
        rd && idx == IW'(0) && $past(ana_q) |-> prdata[3:0] == 4'h0; endproperty
    a_analog_rd: assert property (p_analog_rd) else $error("analog pin read high");
    property p_flags;
        rd && idx == IW'(3) |-> prdata[7] == $past(input_full_flag) && !prdata[3]; endproperty
    a_flags: assert property (p_flags) else $error("neighbour flags wrong");
    property p_pwm_a;
        !parallel_slave_active && pwm_owns_pin[0] |=> pad_out[4] == $past(pwm_channel_a);
    endproperty
    a_pwm_a: assert property (p_pwm_a) else $error("pwm channel not on pin");
    // main scenarios seen at least once
    c_host: cover property (parallel_slave_active && host_drive_en);
    c_pwm: cover property (pwm_owns_pin == 4'hF && pad_oe_n[4] == 1'b0);
    c_digital: cover property (rd && idx == IW'(0) && !ana_q);
endmodule : ebp_port_checker
bind ebp_port ebp_port_checker #(.ADDR_W(ADDR_W)) ebp_port_checker_i (.*);

// *** tb/ebp_port_tb.sv ***
`timescale 1ns/1ps
module ebp_port_tb;
    // every input has a value from time zero
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic host_drive_en = 1'b0, input_full_flag = 1'b0, output_full_flag = 1'b0;
    logic input_overflow_set = 1'b0, pwm_multi_output = 1'b0, pwm_channel_a = 1'b0;
    logic pwm_channel_b = 1'b0, pwm_channel_c = 1'b0, pwm_channel_d = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic [7:0] host_out_data = 8'h00, ext_val = 8'hA5, ext_en = 8'hFF;
    logic [7:0] pad_in, pad_out, pad_oe_n, host_in_data;
    logic [3:0] pwm_owns_pin = 4'h0;
    logic pready, pslverr, parallel_slave_active, rerr;
    logic comparator_one_plus, comparator_one_minus, comparator_two_plus, comparator_two_minus;
    logic [2:0] neighbour_dir;
    int fail_count = 0, checked = 0;
    // device and the board around its pins
    ebp_port ebp_port_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .pad_in, .pad_out, .pad_oe_n, .host_drive_en,
        .host_out_data, .input_full_flag, .output_full_flag, .input_overflow_set,
        .host_in_data, .parallel_slave_active, .pwm_channel_a, .pwm_channel_b,
        .pwm_channel_c, .pwm_channel_d, .pwm_owns_pin, .pwm_multi_output,
        .comparator_one_plus, .comparator_one_minus, .comparator_two_plus,
        .comparator_two_minus, .neighbour_dir);
    ebp_pad_model ebp_pad_model_i (.pad_out, .pad_oe_n, .ext_val, .ext_en, .pad_in);
    initial forever #20 pclk = ~pclk;
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t: got %h, want %h", $time, seen, exp);
        end
    endtask : chk
    // one transfer; the request stands until pready is seen high at an edge
    task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge pclk);
        {psel, penable, pwrite} <= {1'b1, 1'b0, w};
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rdat = prdata;
        rerr = pslverr;
        {psel, penable} <= 2'h0;
    endtask : apb
    task rd(input logic [11:0] a, input logic [7:0] exp);
        apb(1'b0, a, 8'h00);
        chk(rdat, {24'h0, exp});
    endtask : rd
    // pins are registered, so two edges leave them settled
    task pins(input logic [7:0] oe, input logic [7:0] val);
        repeat (2) @(posedge pclk);
        #1;
        chk(pad_oe_n, oe);
        chk(pad_out, val);
    endtask : pins
    // state after reset, analog default and a miss
    task t_reset();
        pins(8'hFF, 8'h00);
        // comparators follow the released low pins while analog select is on
        chk({comparator_two_minus, comparator_two_plus, comparator_one_minus,
             comparator_one_plus}, 4'h5);
        chk(neighbour_dir, 3'h7);
        rd(12'h008, 8'hFF);
        rd(12'h010, 8'h01);
        rd(12'h000, 8'hA0);
        rd(12'h014, 8'h00);
        chk(rerr, 1'b1);
    endtask : t_reset
    // direction, latch and pwm steering of the pins
    task t_pins();
        apb(1'b1, 12'h008, 8'hA5);
        pins(8'hA5, 8'h00);
        apb(1'b1, 12'h008, 8'h00);
        apb(1'b1, 12'h000, 8'h55);
        pins(8'h00, 8'h55);
        rd(12'h000, 8'h50);
        apb(1'b1, 12'h010, 8'h00);
        apb(1'b1, 12'h008, 8'hF0);
        repeat (3) @(posedge pclk);
        rd(12'h000, 8'hA5);
        rd(12'h004, 8'h55);
        chk({comparator_two_minus, comparator_two_plus, comparator_one_minus,
             comparator_one_plus}, 4'h0);
        apb(1'b1, 12'h008, 8'h00);
        pwm_owns_pin <= 4'hF;
        {pwm_channel_d, pwm_channel_c, pwm_channel_b, pwm_channel_a} <= 4'hA;
        pins(8'h00, 8'hA5);
        apb(1'b1, 12'h008, 8'hF0);
        pins(8'hF0, 8'hA5);
    endtask : t_pins
    // slave port ownership, its flags and the multi-output lockout
    task t_host();
        apb(1'b1, 12'h00C, 8'h17);
        pwm_owns_pin <= 4'h0;
        host_drive_en <= 1'b1;
        host_out_data <= 8'hC3;
        pins(8'h00, 8'hC3);
        chk(parallel_slave_active, 1'b1);
        @(posedge pclk);
        host_drive_en <= 1'b0;
        {input_full_flag, output_full_flag, input_overflow_set} <= 3'h7;
        ext_val <= 8'h96;
        @(posedge pclk);
        input_overflow_set <= 1'b0;
        repeat (2) @(posedge pclk);
        #1;
        chk(pad_oe_n, 8'hFF);
        chk(host_in_data, 8'h96);
        rd(12'h00C, 8'hF7);
        apb(1'b1, 12'h00C, 8'h12);
        rd(12'h00C, 8'hD2);
        chk(neighbour_dir, 3'h2);
        pwm_multi_output <= 1'b1;
        host_drive_en <= 1'b1;
        pins(8'hF0, 8'h55);
        chk(parallel_slave_active, 1'b0);
    endtask : t_host
    task finish_test();
        $display("checks %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : finish_test
    // the whole run needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge pclk);
        fail_count++;
        finish_test();
    end
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_pins();
        t_host();
        finish_test();
    end
endmodule : ebp_port_tb
